// >>> hdl/fepseq_consts.vh
// constants for the flash erase/program sequencer
`ifndef FEPSEQ_CONSTS_VH
`define FEPSEQ_CONSTS_VH
// =========
// register byte offsets (apb)
`define FEP_OFF_CTRL      12'h000
`define FEP_OFF_STAT      12'h004
`define FEP_OFF_IBAR      12'h008
`define FEP_OFF_IBDR      12'h00C
`define FEP_OFF_WER0      12'h010
`define FEP_OFF_WER1      12'h014
`define FEP_OFF_WER2      12'h018
`define FEP_OFF_FUNC      12'h01C
`define FEP_OFF_PROT      12'h020
`define FEP_OFF_BOOT      12'h024
// =========
// control bits
`define FEP_CTRL_PE       2
`define FEP_CTRL_PER      1
`define FEP_CTRL_MER      0
// status bits
`define FEP_STAT_BUSY     0
`define FEP_STAT_FULL     1
`define FEP_STAT_ERASE_ERROR_FLAG     2
`define FEP_STAT_PROGRAM_ERROR_FLAG     3
// =========
// protection word fields
`define FEP_PW_WR_HI      15
`define FEP_PW_WR_LO      13
`define FEP_PW_RD_HI      12
`define FEP_PW_RD_LO      10
`define FEP_PW_ISP_HI     9
`define FEP_PW_ISP_LO     7
`define FEP_PW_EMP_HI     6
`define FEP_PW_EMP_LO     4
`define FEP_PW_BA_HI      3
`define FEP_PW_BA_LO      0
`define FEP_BA_NONE       4'hF
`define FEP_FW_USB_BIT    0
// info addresses of the auto-read words
`define FEP_IB_FUNC_ADDR  8'h7E
`define FEP_IB_PROT_ADDR  8'hFE
`define FEP_IB1_BIT       7
// =========
// geometry: byte address bits
`define FEP_BLK_SEL_HI    18
`define FEP_BLK_SEL_LO    17
`define FEP_SEC_HI        16
`define FEP_SEC_LO        13
`define FEP_DSEC_HI       12
`define FEP_DSEC_LO       9
`define FEP_BOOT_SHIFT    11
`define FEP_PAGE_MAIN     12'h0400
`define FEP_PAGE_DATA     12'h0200
// =========
// operation times
`define FEP_T_PROG_NS     20000
`define FEP_T_PERASE_NS   20000000
`define FEP_T_MERASE_NS   200000000
`define FEP_CLK_NS        5
`endif

// >>> hdl/fepseq_top.v
// flash erase/program sequencer with apb registers and start-up decode
// =========
// Overview of operation
// - erase sets every bit to one.
// - page erase needs section enable; never boot area.
// - page is 1024 bytes, 512 in data block.
// - page-erase write starts erase; busy, then error flag.
// - block erase needs all sections, no boot area.
// - info erase takes main block; boot blocks it; no page.
// - info erase: block-erase bit, address, data write.
// - program needs guard, sector enable; never boot area.
// - only aligned 16-bit words.
// - word write programs; busy; full if one running.
// - info program starts on data write; never block 0.
// - reset copies words at 07Eh and 0FEh.
// - usb bit zero forces low power, one follows usb.
// - inverted boot field counts 2k blocks; 1111 none.
// - isp start with no boot area holds reset.
// - isp if blank with both straps high, or low 0 high 1.
// - start-up table picks mode, start or held reset.
// - development mode starts at zero.
// - read-guard clear blocks debug reads only.
// - write-guard clear blocks writes, debug reads.
`timescale 1ns/10ps
`default_nettype none
`include "fepseq_consts.vh"
module fepseq_top #(
    parameter integer PROG_CYC   = `FEP_T_PROG_NS / `FEP_CLK_NS,
    parameter integer PERASE_CYC = `FEP_T_PERASE_NS / `FEP_CLK_NS,
    parameter integer MERASE_CYC = `FEP_T_MERASE_NS / `FEP_CLK_NS
) (
    // clock and reset
    input  wire        clk_i,
    input  wire        sys_rst_i,
    // apb slave
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output wire        pready_o,
    output wire        pslverr_o,
    // cpu write into flash space
    input  wire        fwr_valid_i,
    input  wire [19:0] fwr_addr_i,
    input  wire [15:0] fwr_data_i,
    input  wire        fwr_word_i,
    // info block words captured at reset
    input  wire [15:0] ib_func_word_i,
    input  wire [15:0] ib_prot_word_i,
    // strap pins and mode
    input  wire        env_strap_low_i,
    input  wire        env_strap_high_i,
    input  wire        development_mode_i,
    input  wire        usb_ctrl_power_i,
    // flash array command
    output reg         arr_erase_o,
    output reg         arr_prog_o,
    output reg  [19:0] arr_addr_o,
    output reg  [19:0] arr_len_o,
    output reg  [15:0] arr_data_o,
    output reg  [1:0]  arr_blk_o,
    output reg         arr_info_o,
    // start-up and protection decode
    output reg         insystem_programming_mode_o,
    output reg         run_mode_o,
    output reg         hold_reset_o,
    output reg  [19:0] start_addr_o,
    output reg         debug_read_block_o,
    output reg         usb_xcvr_lowpower_o
);
    // =========
    // state and registers
    localparam [1:0] S_IDLE = 2'b00;
    localparam [1:0] S_RUN  = 2'b01;
    reg [1:0]  st_ff;
    reg [31:0] cnt_ff;
    reg [2:0]  ctrl_ff;
    reg        program_error_flag_ff;
    reg        erase_error_flag_ff;
    reg        full_ff;
    reg [7:0]  ibar_ff;
    reg [15:0] ibdr_ff;
    reg [15:0] wer_ff [0:2];
    reg [15:0] func_ff;
    reg [15:0] prot_ff;
    reg        pend_ff;
    reg [19:0] pend_addr_ff;
    reg [15:0] pend_data_ff;
    reg [1:0]  pend_blk_ff;
    reg        pend_info_ff;
    reg [1:0]  env_s1_ff;
    reg [1:0]  env_s2_ff;
    reg [1:0]  rst_seen_ff;
    // =========
    // two-of-three vote
    function vote3;
        input [2:0] v;
        begin
            vote3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
        end
    endfunction
    // =========
    // protection decode
    wire       wr_ok   = vote3(prot_ff[`FEP_PW_WR_HI:`FEP_PW_WR_LO]);
    wire       rd_ok   = vote3(prot_ff[`FEP_PW_RD_HI:`FEP_PW_RD_LO]);
    wire       isp_fl  = vote3(prot_ff[`FEP_PW_ISP_HI:`FEP_PW_ISP_LO]);
    wire       blank   = vote3(prot_ff[`FEP_PW_EMP_HI:`FEP_PW_EMP_LO]);
    wire [3:0] ba      = prot_ff[`FEP_PW_BA_HI:`FEP_PW_BA_LO];
    wire       ba_def  = (ba != `FEP_BA_NONE);
    wire [19:0] code_start = {12'h000, ~ba, 4'h0} << 7;
    wire busy = (st_ff == S_RUN);
    // =========
    // target classification
    wire [1:0] t_blk   = fwr_addr_i[`FEP_BLK_SEL_HI:`FEP_BLK_SEL_LO];
    wire       t_data  = fwr_addr_i[19];
    wire [1:0] blk_sel = t_data ? 2'd2 : t_blk;
    wire [3:0] sec     = t_data ? fwr_addr_i[`FEP_DSEC_HI:`FEP_DSEC_LO]
                                : fwr_addr_i[`FEP_SEC_HI:`FEP_SEC_LO];
    wire       sec_en  = wer_ff[blk_sel][sec];
    wire       in_boot = ~t_data && (t_blk == 2'd0) &&
                         (fwr_addr_i < code_start);
    wire       boot_blk = (blk_sel == 2'd0) && ba_def;
    wire       all_en  = &wer_ff[blk_sel];
    wire [1:0] ib_blk  = ibar_ff[`FEP_IB1_BIT] ? 2'd1 : 2'd0;
    // =========
    // apb decode
    wire acc   = psel_i & penable_i;
    wire wr    = acc & pwrite_i;
    wire known = (paddr_i <= `FEP_OFF_BOOT) && (paddr_i[1:0] == 2'b00);
    assign pready_o  = 1'b1;
    assign pslverr_o = acc & ~known;
    wire ibdr_wr = wr && (paddr_i == `FEP_OFF_IBDR);
    // a command from either the flash write port or the info data register
    wire cmd_main = fwr_valid_i;
    wire cmd_info = ibdr_wr;
    reg        ok;
    reg        is_erase;
    reg        bad_pe;
    reg [19:0] c_addr;
    reg [19:0] c_len;
    reg [31:0] c_cyc;
    always @* begin
        ok = 1'b0;
        is_erase = 1'b0;
        bad_pe = 1'b0;
        c_addr = fwr_addr_i;
        c_len = 20'h00002;
        c_cyc = PROG_CYC;
        if (cmd_info) begin
            c_addr = {12'h000, ibar_ff};
            if (ctrl_ff[`FEP_CTRL_MER]) begin
                is_erase = 1'b1;
                ok = wr_ok && !(ib_blk == 2'd0 && ba_def);
                c_cyc = MERASE_CYC;
                c_len = 20'h20000;
            end else if (ctrl_ff[`FEP_CTRL_PE]) begin
                ok = wr_ok && (ib_blk != 2'd0);
            end else begin
                is_erase = ctrl_ff[`FEP_CTRL_PER]; // no info page erase
            end
        end else if (cmd_main) begin
            if (ctrl_ff[`FEP_CTRL_MER]) begin
                is_erase = 1'b1;
                ok = wr_ok && all_en && !boot_blk;
                c_cyc = MERASE_CYC;
                c_len = t_data ? 20'h02000 : 20'h20000;
                c_addr = t_data ? 20'hD0000 : {1'b0, t_blk, 17'h00000};
            end else if (ctrl_ff[`FEP_CTRL_PER]) begin
                is_erase = 1'b1;
                ok = wr_ok && sec_en && !in_boot;
                c_cyc = PERASE_CYC;
                c_len = t_data ? {8'h00, `FEP_PAGE_DATA} : {8'h00, `FEP_PAGE_MAIN};
                c_addr = t_data ? {fwr_addr_i[19:9], 9'h000}
                                : {fwr_addr_i[19:10], 10'h000};
            end else if (ctrl_ff[`FEP_CTRL_PE]) begin
                ok = wr_ok && sec_en && !in_boot;
                bad_pe = !fwr_word_i || fwr_addr_i[0];
            end
        end
    end
    wire any_cmd = cmd_main | cmd_info;
    wire do_prog = any_cmd && !is_erase && ctrl_ff[`FEP_CTRL_PE] && !ctrl_ff[`FEP_CTRL_MER];
    wire do_er   = any_cmd && is_erase;
    // =========
    // sequencer
    integer k;
    always @(posedge clk_i) begin
        arr_erase_o <= 1'b0;
        arr_prog_o  <= 1'b0;
        if (sys_rst_i) begin
            st_ff <= S_IDLE;
            cnt_ff <= 32'h0000_0000;
            ctrl_ff <= 3'b000;
            program_error_flag_ff <= 1'b0;
            erase_error_flag_ff <= 1'b0;
            full_ff <= 1'b0;
            ibar_ff <= 8'h00;
            ibdr_ff <= 16'h0000;
            for (k = 0; k < 3; k = k + 1) begin
                wer_ff[k] <= 16'h0000;
            end
            pend_ff <= 1'b0;
            pend_addr_ff <= 20'h0_0000;
            pend_data_ff <= 16'h0000;
            pend_blk_ff <= 2'b00;
            pend_info_ff <= 1'b0;
            arr_addr_o <= 20'h0_0000;
            arr_len_o <= 20'h0_0000;
            arr_data_o <= 16'h0000;
            arr_blk_o <= 2'b00;
            arr_info_o <= 1'b0;
        end else begin
            if (wr) begin
                case (paddr_i)
                    `FEP_OFF_CTRL: ctrl_ff <= pwdata_i[2:0];
                    `FEP_OFF_IBAR: ibar_ff <= {pwdata_i[7:1], 1'b0};
                    `FEP_OFF_IBDR: ibdr_ff <= pwdata_i[15:0];
                    `FEP_OFF_WER0: wer_ff[0] <= pwdata_i[15:0];
                    `FEP_OFF_WER1: wer_ff[1] <= pwdata_i[15:0];
                    `FEP_OFF_WER2: wer_ff[2] <= pwdata_i[15:0];
                    default: ;
                endcase
            end
            // writing one to a status error bit clears it; new errors win
            if (wr && paddr_i == `FEP_OFF_STAT) begin
                if (pwdata_i[`FEP_STAT_ERASE_ERROR_FLAG]) erase_error_flag_ff <= 1'b0;
                if (pwdata_i[`FEP_STAT_PROGRAM_ERROR_FLAG]) program_error_flag_ff <= 1'b0;
            end
            if (do_er && !busy) begin
                if (ok) begin
                    st_ff <= S_RUN;
                    cnt_ff <= c_cyc;
                    arr_erase_o <= 1'b1; // array sets bits to one
                    arr_addr_o <= c_addr;
                    arr_len_o <= c_len;
                    arr_blk_o <= cmd_info ? ib_blk : blk_sel;
                    arr_info_o <= cmd_info;
                end else begin
                    erase_error_flag_ff <= 1'b1;
                end
            end else if (do_prog && !(busy && pend_ff)) begin
                if (!ok || bad_pe) begin
                    program_error_flag_ff <= 1'b1;
                end else if (!busy) begin
                    st_ff <= S_RUN;
                    cnt_ff <= PROG_CYC;
                    arr_prog_o <= 1'b1;
                    arr_addr_o <= c_addr;
                    arr_data_o <= cmd_info ? pwdata_i[15:0] : fwr_data_i;
                    arr_blk_o <= cmd_info ? ib_blk : blk_sel;
                    arr_info_o <= cmd_info;
                end else begin
                    pend_ff <= 1'b1; // second word waits
                    full_ff <= 1'b1;
                    pend_addr_ff <= c_addr;
                    pend_data_ff <= cmd_info ? pwdata_i[15:0] : fwr_data_i;
                    pend_blk_ff <= cmd_info ? ib_blk : blk_sel;
                    pend_info_ff <= cmd_info;
                end
            end else if (any_cmd && busy) begin
                // over-run: software ignored the full flag, or the busy flag for an erase
                if (do_prog) program_error_flag_ff <= 1'b1;
                else if (do_er) erase_error_flag_ff <= 1'b1;
            end
            if (busy) begin
                if (cnt_ff > 32'h0000_0001) begin
                    cnt_ff <= cnt_ff - 32'h0000_0001;
                end else if (pend_ff) begin
                    cnt_ff <= PROG_CYC;
                    arr_prog_o <= 1'b1;
                    arr_addr_o <= pend_addr_ff;
                    arr_data_o <= pend_data_ff;
                    arr_blk_o <= pend_blk_ff;
                    arr_info_o <= pend_info_ff;
                    pend_ff <= 1'b0;
                    full_ff <= 1'b0;
                end else begin
                    st_ff <= S_IDLE;
                end
            end
        end
    end
    // =========
    // reset-time capture and strap sync
    always @(posedge clk_i) begin
        env_s1_ff <= {env_strap_high_i, env_strap_low_i};
        env_s2_ff <= env_s1_ff;
        if (sys_rst_i) begin
            rst_seen_ff <= 2'b00;
            func_ff <= 16'h0000;
            prot_ff <= 16'h0000;
        end else if (rst_seen_ff != 2'b11) begin
            // straps need two cycles through the synchroniser
            rst_seen_ff <= rst_seen_ff + 2'b01;
            func_ff <= ib_func_word_i;
            prot_ff <= ib_prot_word_i;
        end
    end
    // =========
    // start-up decision, registered every cycle; reset held until capture ends
    reg isp_n;
    reg run_n;
    reg hold_n;
    reg [19:0] sa_n;
    always @* begin
        isp_n = 1'b0;
        run_n = 1'b0;
        hold_n = 1'b0;
        sa_n = 20'h0_0000;
        if (development_mode_i) begin
            run_n = 1'b1;
        end else if ((!env_s2_ff[0] && env_s2_ff[1]) || (blank && &env_s2_ff)) begin
            isp_n = 1'b1;
            hold_n = !ba_def || !isp_fl;
            sa_n = code_start;
        end else if (!blank) begin
            run_n = 1'b1;
            sa_n = isp_fl ? code_start : 20'h0_0000;
        end else begin
            hold_n = 1'b1;
        end
    end
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            insystem_programming_mode_o <= 1'b0;
            run_mode_o <= 1'b0;
            hold_reset_o <= 1'b1;
            start_addr_o <= 20'h0_0000;
            debug_read_block_o <= 1'b1;
            usb_xcvr_lowpower_o <= 1'b1;
        end else begin
            insystem_programming_mode_o <= isp_n;
            run_mode_o <= run_n;
            hold_reset_o <= hold_n || (rst_seen_ff != 2'b11);
            start_addr_o <= sa_n;
            debug_read_block_o <= !rd_ok || !wr_ok;
            usb_xcvr_lowpower_o <= !func_ff[`FEP_FW_USB_BIT] || !usb_ctrl_power_i;
        end
    end
    // =========
    // apb read mux
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            case (paddr_i)
                `FEP_OFF_CTRL: prdata_o <= {29'h0000_0000, ctrl_ff};
                `FEP_OFF_STAT: prdata_o <= {28'h000_0000, program_error_flag_ff, erase_error_flag_ff, full_ff, busy};
                `FEP_OFF_IBAR: prdata_o <= {24'h00_0000, ibar_ff};
                `FEP_OFF_IBDR: prdata_o <= {16'h0000, ibdr_ff};
                `FEP_OFF_WER0: prdata_o <= {16'h0000, wer_ff[0]};
                `FEP_OFF_WER1: prdata_o <= {16'h0000, wer_ff[1]};
                `FEP_OFF_WER2: prdata_o <= {16'h0000, wer_ff[2]};
                `FEP_OFF_FUNC: prdata_o <= {16'h0000, func_ff};
                `FEP_OFF_PROT: prdata_o <= {16'h0000, prot_ff};
                `FEP_OFF_BOOT: prdata_o <= {12'h000, code_start};
                default:       prdata_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule // fepseq_top
`default_nettype wire

// >>> testbench/fepseq_chk_sva.sv
// assertion checker for the flash erase/program sequencer ports
`timescale 1ns/10ps
`default_nettype none
module fepseq_chk (
    // clock, reset and start-up inputs
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic [15:0] ib_func_word_i,
    input wire logic [15:0] ib_prot_word_i,
    input wire logic        env_strap_low_i,
    input wire logic        env_strap_high_i,
    input wire logic        development_mode_i,
    // array command and start-up outputs
    input wire logic        arr_erase_o,
    input wire logic        arr_prog_o,
    input wire logic [19:0] arr_addr_o,
    input wire logic [19:0] arr_len_o,
    input wire logic [1:0]  arr_blk_o,
    input wire logic        arr_info_o,
    input wire logic        run_mode_o,
    input wire logic        hold_reset_o,
    input wire logic [19:0] start_addr_o,
    input wire logic        debug_read_block_o,
    input wire logic        usb_xcvr_lowpower_o
);
    // =========
    // words captured while reset is held; decode settles by count 7
    logic [15:0] pw_ff;
    logic [15:0] fw_ff;
    logic [2:0]  cnt_ff;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pw_ff  <= ib_prot_word_i;
            fw_ff  <= ib_func_word_i;
            cnt_ff <= 3'd0;
        end else if (cnt_ff != 3'd7) begin
            cnt_ff <= cnt_ff + 3'd1;
        end
    end
    function automatic logic maj(input logic [2:0] v);
        return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction
    wire logic        up_w   = (cnt_ff == 3'd7) && !development_mode_i;
    wire logic        blank  = maj(pw_ff[6:4]);
    wire logic        isp_w  = maj(pw_ff[9:7]);
    wire logic [19:0] boot_w = {5'd0, ~pw_ff[3:0], 11'd0};
    wire logic        strap_isp = !env_strap_low_i && env_strap_high_i;
    // =========
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    a_erase_pulse: assert property (arr_erase_o |=> !arr_erase_o && !arr_prog_o)
        else $error("erase command not a single pulse");
    a_prog_pulse: assert property (arr_prog_o |=> !arr_prog_o)
        else $error("program command not a single pulse");
    a_erase_len: assert property (arr_erase_o && !arr_info_o |-> (arr_blk_o == 2'd2) ?
        (arr_len_o == 20'h0_0200 || arr_len_o == 20'h0_2000) :
        (arr_len_o == 20'h0_0400 || arr_len_o == 20'h2_0000))
        else $error("erase length wrong for block");
    a_page_align: assert property (arr_erase_o && arr_len_o == 20'h0_0400 |-> arr_addr_o[9:0] == 10'h000)
        else $error("page erase not page aligned");
    a_boot_erase: assert property (arr_erase_o && arr_blk_o == 2'd0 && pw_ff[3:0] != 4'hF
        |-> arr_addr_o >= boot_w && !arr_info_o && arr_len_o == 20'h0_0400)
        else $error("erase reaches boot region");
    a_boot_prog: assert property (arr_prog_o && !arr_info_o && arr_blk_o == 2'd0 |-> arr_addr_o >= boot_w)
        else $error("program inside boot region");
    a_prog_align: assert property (arr_prog_o |-> arr_addr_o[0] == 1'b0)
        else $error("program address not word aligned");
    a_no_factory: assert property (arr_prog_o && arr_info_o |-> arr_blk_o != 2'd0)
        else $error("factory info block programmed");
    a_guard_dec: assert property (cnt_ff == 3'd7 |-> debug_read_block_o == (!maj(pw_ff[12:10]) || !maj(pw_ff[15:13])))
        else $error("debug read block decode wrong");
    a_usb_low: assert property (cnt_ff == 3'd7 && !fw_ff[0] |-> usb_xcvr_lowpower_o)
        else $error("transceiver not forced to low power");
    a_isp_noboot: assert property (up_w && blank && env_strap_low_i && env_strap_high_i && pw_ff[3:0] == 4'hF |-> hold_reset_o)
        else $error("isp start without boot region not held");
    a_run_start: assert property (up_w && !blank && !strap_isp
        |-> run_mode_o && !hold_reset_o && start_addr_o == (isp_w ? boot_w : 20'h0_0000))
        else $error("normal start address wrong");
    c_info_erase: cover property (arr_erase_o && arr_info_o);
    c_pipe: cover property (arr_prog_o ##[1:40] arr_prog_o);
    c_held: cover property (hold_reset_o && cnt_ff == 3'd7);
endmodule // fepseq_chk
bind fepseq_top fepseq_chk u_chk (.*);
`default_nettype wire

// >>> testbench/fepseq_cpu.sv
// cpu-side model: apb register master and flash-space writer
`timescale 1ns/10ps
`default_nettype none
module fepseq_cpu (
    // clock and apb
    input  wire logic        clk_i,
    output var  logic        psel_o,
    output var  logic        penable_o,
    output var  logic        pwrite_o,
    output var  logic [11:0] paddr_o,
    output var  logic [31:0] pwdata_o,
    input  wire logic [31:0] prdata_i,
    input  wire logic        pready_i,
    input  wire logic        pslverr_i,
    // flash-space writes
    output var  logic        fwr_valid_o,
    output var  logic [19:0] fwr_addr_o,
    output var  logic [15:0] fwr_data_o,
    output var  logic        fwr_word_o
);
    initial begin
        {psel_o, penable_o, pwrite_o, fwr_valid_o} = 4'h0;
        {paddr_o, pwdata_o, fwr_addr_o, fwr_data_o} = 80'h0;
        fwr_word_o = 1'b1;
    end
    // =========
    // released address and data lines are inverted so stale values never look valid
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge clk_i);
        psel_o    <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o  <= w;
        paddr_o   <= a;
        pwdata_o  <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        do @(posedge clk_i); while (pready_i !== 1'b1);
        q = prdata_i;
        e = pslverr_i;
        psel_o    <= 1'b0;
        penable_o <= 1'b0;
        paddr_o   <= ~a;
        pwdata_o  <= ~d;
    endtask
    task automatic fwr(input logic [19:0] a, input logic [15:0] d, input logic w);
        @(posedge clk_i);
        fwr_valid_o <= 1'b1;
        fwr_addr_o  <= a;
        fwr_data_o  <= d;
        fwr_word_o  <= w;
        @(posedge clk_i);
        fwr_valid_o <= 1'b0;
        fwr_addr_o  <= ~a;
        fwr_data_o  <= ~d;
    endtask
    // polls status until the masked bits clear or 200 reads have been made
    task automatic wait_clr(input logic [31:0] m, output logic [31:0] s);
        logic e;
        int   i;
        i = 0;
        do begin
            apb(1'b0, 12'h004, 32'h0000_0000, s, e);
            i++;
        end while ((s & m) != 32'h0000_0000 && i < 200);
    endtask
endmodule // fepseq_cpu
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking testbench for the flash erase/program sequencer
`timescale 1ns/10ps
`default_nettype none
`include "fepseq_consts.vh"
module tb_top;
    // =========
    // stimulus and wiring
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [15:0] prot_w = 16'hFFFF;
    logic [15:0] func_w = 16'h0000;
    logic        usb_pw = 1'b0;
    logic        dev_m = 1'b0;
    logic [31:0] q;
    logic        e;
    logic [7:0]  n_er = 8'd0;
    logic [7:0]  n_pr = 8'd0;
    int          n_errors = 0;
    int          n_checks = 0;
    int          cyc = 0;
    wire logic        psel, penable, pwrite, pready, pslverr, fv, fw;
    wire logic [11:0] paddr;
    wire logic [31:0] pwdata, prdata;
    wire logic [19:0] fa, arr_addr, arr_len, start_a;
    wire logic [15:0] fd, arr_data;
    wire logic [1:0]  arr_blk;
    wire logic        arr_erase, arr_prog, arr_info, ispm, runm, holdr, dbg_blk, usb_lp;
    initial forever #2.5 clk_i = ~clk_i;
    fepseq_cpu cpu (.clk_i(clk_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
        .pslverr_i(pslverr), .fwr_valid_o(fv), .fwr_addr_o(fa), .fwr_data_o(fd), .fwr_word_o(fw));
    fepseq_top #(.PROG_CYC(16), .PERASE_CYC(20), .MERASE_CYC(30)) DUT (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .fwr_valid_i(fv), .fwr_addr_i(fa), .fwr_data_i(fd), .fwr_word_i(fw),
        .ib_func_word_i(func_w), .ib_prot_word_i(prot_w), .env_strap_low_i(1'b1),
        .env_strap_high_i(1'b1), .development_mode_i(dev_m), .usb_ctrl_power_i(usb_pw),
        .arr_erase_o(arr_erase), .arr_prog_o(arr_prog), .arr_addr_o(arr_addr),
        .arr_len_o(arr_len), .arr_data_o(arr_data), .arr_blk_o(arr_blk), .arr_info_o(arr_info),
        .insystem_programming_mode_o(ispm), .run_mode_o(runm), .hold_reset_o(holdr),
        .start_addr_o(start_a), .debug_read_block_o(dbg_blk), .usb_xcvr_lowpower_o(usb_lp));
    // pulse counters and hang guard
    always @(posedge clk_i) begin
        n_er <= n_er + {7'd0, arr_erase === 1'b1};
        n_pr <= n_pr + {7'd0, arr_prog === 1'b1};
        cyc  <= cyc + 1;
        if (cyc == 30000) begin
            n_errors++;
            report_and_stop();
        end
    end
    // =========
    // checking and access tasks
    task automatic chk(input logic [47:0] s, input logic [47:0] x);
        n_checks++;
        if (s !== x) begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, s, x);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        cpu.apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        cpu.apb(1'b0, a, 32'h0000_0000, q, e);
        chk(q, x);
    endtask
    // one command, then busy, outcome, clear
    task automatic op(input logic k, input logic [19:0] a, input logic [15:0] d,
                      input logic w, input logic [31:0] st);
        cpu.wait_clr(32'h0000_0001, q);
        if (k) begin
            wr(`FEP_OFF_IBAR, {24'h00_0000, a[7:0]});
            wr(`FEP_OFF_IBDR, {16'h0000, d});
        end else begin
            cpu.fwr(a, d, w);
        end
        rd(`FEP_OFF_STAT, st);
        cpu.wait_clr(32'h0000_0003, q);
        chk(q, st & 32'h0000_000C);
        wr(`FEP_OFF_STAT, 32'h0000_000C);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // =========
    // main sequence
    initial begin
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        chk({holdr, dbg_blk}, 2'b10);
        sys_rst_i <= 1'b1;
        prot_w    <= 16'hC78D;
        func_w    <= 16'h0001;
        usb_pw    <= 1'b1;
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        chk({holdr, runm, ispm, dbg_blk, usb_lp, start_a}, {5'b01010, 20'h0_1000});
        rd(`FEP_OFF_PROT, 32'h0000_C78D);
        rd(`FEP_OFF_BOOT, 32'h0000_1000);
        rd(12'h030, 32'h0000_0000);
        chk(e, 1'b1);
        wr(`FEP_OFF_WER0, 32'h0000_FFFF);
        wr(`FEP_OFF_WER1, 32'h0000_FFFF);
        wr(`FEP_OFF_WER2, 32'h0000_FFFF);
        rd(`FEP_OFF_WER2, 32'h0000_FFFF);
        wr(`FEP_OFF_CTRL, 32'h0000_0002);
        op(1'b0, 20'h0_2400, 16'h0000, 1'b1, 32'h1);
        chk({arr_blk, arr_info, arr_addr, arr_len}, {3'b000, 20'h0_2400, 20'h0_0400});
        op(1'b0, 20'h0_0800, 16'h0000, 1'b1, 32'h4);
        op(1'b0, 20'hD_0600, 16'h0000, 1'b1, 32'h1);
        chk({arr_blk, arr_info, arr_len}, {3'b100, 20'h0_0200});
        op(1'b1, 20'h0_0080, 16'h0000, 1'b1, 32'h4);
        wr(`FEP_OFF_WER0, 32'h0000_0001);
        op(1'b0, 20'h0_2400, 16'h0000, 1'b1, 32'h4);
        wr(`FEP_OFF_WER0, 32'h0000_FFFF);
        wr(`FEP_OFF_CTRL, 32'h0000_0001);
        op(1'b0, 20'h2_0000, 16'h0000, 1'b1, 32'h1);
        chk({arr_blk, arr_info, arr_len}, {3'b010, 20'h2_0000});
        op(1'b0, 20'h0_0000, 16'h0000, 1'b1, 32'h4);
        op(1'b1, 20'h0_0080, 16'h1234, 1'b1, 32'h1);
        chk({arr_blk, arr_info}, 3'b011);
        op(1'b1, 20'h0_0000, 16'h1234, 1'b1, 32'h4);
        chk(n_er, 8'd4);
        wr(`FEP_OFF_CTRL, 32'h0000_0004);
        cpu.fwr(20'h2_0010, 16'h1234, 1'b1);
        cpu.fwr(20'h2_0012, 16'hABCD, 1'b1);
        rd(`FEP_OFF_STAT, 32'h0000_0003);
        cpu.wait_clr(32'h0000_0002, q);
        cpu.wait_clr(32'h0000_0001, q);
        chk({q[15:0], arr_addr, arr_data}, {16'h0000, 20'h2_0012, 16'hABCD});
        chk(n_pr, 8'd2);
        op(1'b0, 20'h2_0011, 16'h1111, 1'b1, 32'h8);
        op(1'b0, 20'h2_0014, 16'h1111, 1'b0, 32'h8);
        op(1'b0, 20'h0_0010, 16'h1111, 1'b1, 32'h8);
        op(1'b1, 20'h0_0010, 16'h5555, 1'b1, 32'h8);
        op(1'b1, 20'h0_0090, 16'h5555, 1'b1, 32'h1);
        chk({arr_blk, arr_info, arr_data, n_pr}, {3'b011, 16'h5555, 8'd3});
        wr(`FEP_OFF_CTRL, 32'h0000_0000);
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
